// ---- src/ccc_top.sv ----
// compensation control register with axi4-lite slave
// Notes on behaviour
// - shunt break enable written only with mask 15
// - amp short written only with mask 13
// - offset cal start written only with mask 12
// - voltage injection written only with mask 11
// - current injection written only with mask 10
// - temperature injection written only with mask 9
// - cal irq enable written only with mask 8
// - register decodes at 0xA0, both bases
// - shunt status valid only while detection enabled
// - amp short bit shorts amplifier inputs
// - start bit launches offset cal, done flag
// - start bit stays set after completion
// - new calibration needs start bit cleared first
// - voltage injection bit drives voltage reference switch
// - current injection bit drives current reference switch
// - temperature injection bit drives temperature reference switch
// - cal interrupt raised only when enabled
// - done flag sets on finish, write-one clears
// - shunt status reads 1 when disconnected
//
// The AXI4-Lite interface to the registers was left to the implementer.
module ccc_top
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CE_IN,
  input  wire logic [13:0] S_AXI_AWADDR_IN,
  input  wire logic        S_AXI_AWVALID_IN,
  output logic             S_AXI_AWREADY_OUT,
  input  wire logic [31:0] S_AXI_WDATA_IN,
  input  wire logic [3:0]  S_AXI_WSTRB_IN,
  input  wire logic        S_AXI_WVALID_IN,
  output logic             S_AXI_WREADY_OUT,
  output logic [1:0]       S_AXI_BRESP_OUT,
  output logic             S_AXI_BVALID_OUT,
  input  wire logic        S_AXI_BREADY_IN,
  input  wire logic [13:0] S_AXI_ARADDR_IN,
  input  wire logic        S_AXI_ARVALID_IN,
  output logic             S_AXI_ARREADY_OUT,
  output logic [31:0]      S_AXI_RDATA_OUT,
  output logic [1:0]       S_AXI_RRESP_OUT,
  output logic             S_AXI_RVALID_OUT,
  input  wire logic        S_AXI_RREADY_IN,
  input  wire logic        OFS_CAL_DONE_IN,
  input  wire logic        SHUNT_OPEN_IN,
  input  wire logic        CAL_REQ_EVENT_IN,
  output logic             SHUNT_DETECT_EN_OUT,
  output logic             AMP_SHORT_OUT,
  output logic             OFS_CAL_LAUNCH_OUT,
  output logic             VOLT_REF_INJECT_OUT,
  output logic             CURR_REF_INJECT_OUT,
  output logic             TEMP_REF_INJECT_OUT,
  output logic             CAL_IRQ_OUT
);
  logic [13:0] aw_addr_q;
  logic        aw_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_have_q;
  logic        wr_fire;
  logic [11:0] wr_ofs;
  logic        wr_ctl;
  logic        wr_sr;
  logic        wr_ok;
  logic [7:0]  ctl_q;
  logic        start_prev_q;
  logic        shunt_open_q;
  logic        ofs_done;
  logic        cal_req;
  logic [11:0] rd_ofs;
  logic [31:0] rd_data_d;
  logic        rd_ok_d;
  logic        ce;

  assign ce = CE_IN;

  // byte address is four times the register index; strip either base
  function automatic logic [11:0] ccc_offset(input logic [13:0] a);
    logic [11:0] idx;
    logic [11:0] r;
    idx = a[13:2];
    r   = {4'h0, idx[7:0]};
    if ((idx & 12'hF00) != ccc_pkg::BASE_BLOCKING &&
        (idx & 12'hF00) != ccc_pkg::BASE_NONBLOCK)
      r = 12'hFFF;
    return r;
  endfunction

  // write address and data are taken independently
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 14'h0000;
    end
    else if (ce)
    begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR_IN;
      end
      else if (wr_fire)
        aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else if (ce)
    begin
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT)
      begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA_IN;
        w_strb_q <= S_AXI_WSTRB_IN;
      end
      else if (wr_fire)
        w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      S_AXI_AWREADY_OUT <= 1'b0;
      S_AXI_WREADY_OUT  <= 1'b0;
    end
    else if (ce)
    begin
      S_AXI_AWREADY_OUT <= !aw_have_q && !S_AXI_AWREADY_OUT &&
                           !S_AXI_BVALID_OUT;
      S_AXI_WREADY_OUT  <= !w_have_q && !S_AXI_WREADY_OUT &&
                           !S_AXI_BVALID_OUT;
    end
  end

  assign wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID_OUT;
  assign wr_ofs  = ccc_offset(aw_addr_q);
  // only a full low half-word write reaches the register
  assign wr_ok   = (w_strb_q & ccc_pkg::STRB_HALF_LO) ==
                   ccc_pkg::STRB_HALF_LO;
  assign wr_ctl  = wr_fire && wr_ok &&
                   wr_ofs == ccc_pkg::OFS_COMPENSATION_CONTROL;
  assign wr_sr   = wr_fire && wr_ok && wr_ofs == ccc_pkg::OFS_COMP_SR;

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= ccc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_fire)
      begin
        S_AXI_BVALID_OUT <= 1'b1;
        if (wr_ok && (wr_ofs == ccc_pkg::OFS_COMPENSATION_CONTROL ||
                      wr_ofs == ccc_pkg::OFS_COMP_SR))
          S_AXI_BRESP_OUT <= ccc_pkg::RESP_OKAY;
        else
          S_AXI_BRESP_OUT <= ccc_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BREADY_IN)
        S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // masked control bits; bit 6 and mask 14 have no storage
  for (genvar i = 0; i < 8; i++)
  begin : g_ctl
    if (ccc_pkg::CTL_WRITABLE[i])
    begin : g_bit
      ccc_mask_bit u_bit
      (
        .CLK_SYS_IN (CLK_SYS_IN),
        .RST_N_IN   (RST_N_IN),
        .ce_in      (ce),
        .wr_in      (wr_ctl),
        .mask_in    (w_data_q[ccc_pkg::MASK_SHIFT + i]),
        .data_in    (w_data_q[i]),
        .bit_out    (ctl_q[i])
      );
    end
    else
    begin : g_res
      assign ctl_q[i] = 1'b0;
    end
  end

  // status flags
  ccc_sticky_flag u_ofs_done
  (
    .CLK_SYS_IN (CLK_SYS_IN),
    .RST_N_IN   (RST_N_IN),
    .ce_in      (ce),
    .set_in     (OFS_CAL_DONE_IN),
    .clr_in     (wr_sr && w_data_q[ccc_pkg::SR_OFS_DONE]),
    .flag_out   (ofs_done)
  );

  ccc_sticky_flag u_cal_req
  (
    .CLK_SYS_IN (CLK_SYS_IN),
    .RST_N_IN   (RST_N_IN),
    .ce_in      (ce),
    .set_in     (CAL_REQ_EVENT_IN),
    .clr_in     (wr_sr && w_data_q[ccc_pkg::SR_CAL_REQ]),
    .flag_out   (cal_req)
  );

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      shunt_open_q <= 1'b0;
    else if (ce)
      shunt_open_q <= ctl_q[ccc_pkg::BIT_SHUNT_EN] &&
                      SHUNT_OPEN_IN;
  end

  // analog controls and launch pulse on a rising start bit
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      start_prev_q        <= 1'b0;
      OFS_CAL_LAUNCH_OUT  <= 1'b0;
      SHUNT_DETECT_EN_OUT <= 1'b0;
      AMP_SHORT_OUT       <= 1'b0;
      VOLT_REF_INJECT_OUT <= 1'b0;
      CURR_REF_INJECT_OUT <= 1'b0;
      TEMP_REF_INJECT_OUT <= 1'b0;
      CAL_IRQ_OUT         <= 1'b0;
    end
    else if (ce)
    begin
      start_prev_q        <= ctl_q[ccc_pkg::BIT_OFS_START];
      OFS_CAL_LAUNCH_OUT  <= ctl_q[ccc_pkg::BIT_OFS_START] &&
                             !start_prev_q;
      SHUNT_DETECT_EN_OUT <= ctl_q[ccc_pkg::BIT_SHUNT_EN];
      AMP_SHORT_OUT       <= ctl_q[ccc_pkg::BIT_AMP_SHORT];
      VOLT_REF_INJECT_OUT <= ctl_q[ccc_pkg::BIT_VOLT_INJ];
      CURR_REF_INJECT_OUT <= ctl_q[ccc_pkg::BIT_CURR_INJ];
      TEMP_REF_INJECT_OUT <= ctl_q[ccc_pkg::BIT_TEMP_INJ];
      CAL_IRQ_OUT         <= cal_req &&
                             ctl_q[ccc_pkg::BIT_IRQ_EN];
    end
  end

  // read channel
  assign rd_ofs = ccc_offset(S_AXI_ARADDR_IN);

  always_comb
  begin
    rd_data_d = 32'h0000_0000;
    rd_ok_d   = 1'b1;
    if (rd_ofs == ccc_pkg::OFS_COMPENSATION_CONTROL)
      rd_data_d[7:0] = ctl_q & ccc_pkg::CTL_WRITABLE;
    else if (rd_ofs == ccc_pkg::OFS_COMP_SR)
    begin
      rd_data_d[ccc_pkg::SR_SHUNT_OPEN] = shunt_open_q;
      rd_data_d[ccc_pkg::SR_OFS_DONE]   = ofs_done;
      rd_data_d[ccc_pkg::SR_CAL_REQ]    = cal_req;
    end
    else
      rd_ok_d = 1'b0;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_RDATA_OUT   <= 32'h0000_0000;
      S_AXI_RRESP_OUT   <= ccc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      S_AXI_ARREADY_OUT <= !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT &&
                           S_AXI_ARVALID_IN;
      if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
      begin
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RDATA_OUT  <= rd_data_d;
        S_AXI_RRESP_OUT  <= rd_ok_d ? ccc_pkg::RESP_OKAY
                                    : ccc_pkg::RESP_SLVERR;
      end
      else if (S_AXI_RREADY_IN)
        S_AXI_RVALID_OUT <= 1'b0;
    end
  end

  // checks
  shunt_gate_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    !ctl_q[ccc_pkg::BIT_SHUNT_EN] && CE_IN |=> !shunt_open_q)
    else $error("shunt status set while detection off");
  mask_hold_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    wr_ctl && CE_IN && !w_data_q[ccc_pkg::MASK_SHIFT + ccc_pkg::BIT_SHUNT_EN]
    |=> $stable(ctl_q[ccc_pkg::BIT_SHUNT_EN]))
    else $error("shunt enable changed without mask");
  mask_write_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    wr_ctl && CE_IN && w_data_q[ccc_pkg::MASK_SHIFT + ccc_pkg::BIT_AMP_SHORT]
    |=> ctl_q[ccc_pkg::BIT_AMP_SHORT] ==
        $past(w_data_q[ccc_pkg::BIT_AMP_SHORT]))
    else $error("amp short not written with mask");
  start_hold_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    ctl_q[ccc_pkg::BIT_OFS_START] && !wr_ctl |=>
    ctl_q[ccc_pkg::BIT_OFS_START])
    else $error("start bit cleared itself");
  launch_rise_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    ctl_q[ccc_pkg::BIT_OFS_START] && !start_prev_q && CE_IN
    |=> OFS_CAL_LAUNCH_OUT)
    else $error("launch missing on start");
  launch_once_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    OFS_CAL_LAUNCH_OUT && CE_IN |=> !OFS_CAL_LAUNCH_OUT)
    else $error("launch repeated without clear");
  done_set_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    OFS_CAL_DONE_IN && CE_IN |=> ofs_done)
    else $error("done flag not set");
  done_clear_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    wr_sr && CE_IN && w_data_q[ccc_pkg::SR_OFS_DONE] && !OFS_CAL_DONE_IN
    |=> !ofs_done)
    else $error("done flag not cleared by write");
  irq_gate_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    !ctl_q[ccc_pkg::BIT_IRQ_EN] && CE_IN |=> !CAL_IRQ_OUT)
    else $error("irq raised while disabled");
  inject_follow_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    CE_IN |=> VOLT_REF_INJECT_OUT == $past(ctl_q[ccc_pkg::BIT_VOLT_INJ]))
    else $error("voltage injection mismatch");
  reserved_zero_a: assert property (
    @(posedge CLK_SYS_IN) disable iff (!RST_N_IN)
    S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[15:8] == 8'h00)
    else $error("mask bits read nonzero");
endmodule

// ---- src/ccc_pkg.sv ----
// package: register map, field positions and reset values
package ccc_pkg;
  localparam int unsigned ADDR_W          = 14;
  localparam logic [11:0] BASE_BLOCKING   = 12'hE00;
  localparam logic [11:0] BASE_NONBLOCK   = 12'hF00;
  localparam logic [11:0] OFS_COMPENSATION_CONTROL    = 12'h0A0;
  localparam logic [11:0] OFS_COMP_SR     = 12'h0A2;
  localparam logic [11:0] OFS_CAL_EVENTS  = 12'h0A4;
  localparam int unsigned BIT_IRQ_EN      = 0;
  localparam int unsigned BIT_TEMP_INJ    = 1;
  localparam int unsigned BIT_CURR_INJ    = 2;
  localparam int unsigned BIT_VOLT_INJ    = 3;
  localparam int unsigned BIT_OFS_START   = 4;
  localparam int unsigned BIT_AMP_SHORT   = 5;
  localparam int unsigned BIT_SHUNT_EN    = 7;
  localparam int unsigned MASK_SHIFT      = 8;
  localparam logic [7:0]  CTL_WRITABLE    = 8'hBF;
  localparam logic [7:0]  CTL_RESET       = 8'h00;
  localparam int unsigned SR_SHUNT_OPEN   = 7;
  localparam int unsigned SR_OFS_DONE     = 4;
  localparam int unsigned SR_CAL_REQ      = 0;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;
  localparam logic [3:0]  STRB_HALF_LO    = 4'h3;
endpackage

// ---- src/ccc_sticky_flag.sv ----
// sticky status flag: set wins over write-one clear
module ccc_sticky_flag
(
  input  wire logic CLK_SYS_IN,
  input  wire logic RST_N_IN,
  input  wire logic ce_in,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      flag_out
);
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      flag_out <= 1'b0;
    else if (ce_in)
    begin
      if (set_in)
        flag_out <= 1'b1;
      else if (clr_in)
        flag_out <= 1'b0;
    end
  end
endmodule

// ---- src/ccc_mask_bit.sv ----
// one control bit written only when its mask bit is set in the same write
module ccc_mask_bit
(
  input  wire logic CLK_SYS_IN,
  input  wire logic RST_N_IN,
  input  wire logic ce_in,
  input  wire logic wr_in,
  input  wire logic mask_in,
  input  wire logic data_in,
  output logic      bit_out
);
  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      bit_out <= 1'b0;
    else if (ce_in && wr_in && mask_in)
      bit_out <= data_in;
  end
endmodule

// ---- test/ccc_top_bench.sv ----
// self-checking bench for the compensation control register
module ccc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, rst_n = 0, ce = 1;
  logic [13:0] awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0]  wstrb = 0;
  logic        done_in = 0, open_in = 0, req_in = 0, flag = 0;
  wire logic   awready, wready, bvalid, arready, rvalid, irq;
  wire logic   sh_en, short_o, launch, v_inj, i_inj, t_inj;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [5:0]  outs;
  logic [31:0] q;
  logic [1:0]  r;
  logic [7:0]  ctl = 0;
  integer      seed = 32'h5BFA70A0;
  int          n_mismatch = 0, samples_checked = 0, launches = 0, exp_l = 0;

  ccc_top u_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .OFS_CAL_DONE_IN(done_in),
    .SHUNT_OPEN_IN(open_in), .CAL_REQ_EVENT_IN(req_in),
    .SHUNT_DETECT_EN_OUT(sh_en), .AMP_SHORT_OUT(short_o),
    .OFS_CAL_LAUNCH_OUT(launch), .VOLT_REF_INJECT_OUT(v_inj),
    .CURR_REF_INJECT_OUT(i_inj), .TEMP_REF_INJECT_OUT(t_inj),
    .CAL_IRQ_OUT(irq));

  always #10 clk = ~clk;

  assign outs = {sh_en, short_o, v_inj, i_inj, t_inj, irq};

  always @(posedge clk)
  begin
    if (launch === 1'b1)
      launches <= launches + 1;
  end

  function automatic logic [7:0] nxt(logic [7:0] c, logic [15:0] d);
    logic [7:0] m;
    m = d[15:8] & 8'hBF;
    return (c & ~m) | (d[7:0] & m);
  endfunction

  // expected status word from its three flags
  function automatic logic [7:0] sr(logic sh, logic dn, logic rq);
    logic [7:0] v;
    v = 8'h00;
    v[ccc_pkg::SR_SHUNT_OPEN] = sh;
    v[ccc_pkg::SR_OFS_DONE]   = dn;
    v[ccc_pkg::SR_CAL_REQ]    = rq;
    return v;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    @(posedge clk);
    awaddr  <= {a, 2'b00};
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1 && awvalid) awvalid <= 1'b0;
      if (wready === 1'b1 && wvalid) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    @(posedge clk);
    araddr  <= {a, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready === 1'b1 && arvalid) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    q = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic step(input logic [11:0] a, input logic [15:0] d,
                      input logic [3:0] s);
    logic       ok;
    logic [7:0] nx;
    logic [1:0] er;
    logic [5:0] ex;
    ok = (a == 12'hEA0 || a == 12'hFA0) && s[1:0] == 2'b11;
    nx = ok ? nxt(ctl, d) : ctl;
    er = ok ? ccc_pkg::RESP_OKAY : ccc_pkg::RESP_SLVERR;
    axi_wr(a, {16'($random(seed)), d}, s);
    chk("bresp", er, r);
    if (!ctl[4] && nx[4]) exp_l++;
    ctl = nx;
    ex = {ctl[7], ctl[5], ctl[3:1], flag & ctl[0]};
    repeat (3) @(posedge clk);
    chk("outputs", ex, outs);
    chk("launches", exp_l, launches);
    axi_rd(12'hFA0);
    chk("readback", {24'h0, ctl}, q);
    chk("rresp", ccc_pkg::RESP_OKAY, r);
  endtask

  // read the status word and compare it
  task automatic sr_chk(input logic [7:0] e);
    axi_rd(12'hEA2);
    chk("status", {24'h0, e}, q);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    print_verdict;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(12'hEA0);
    chk("reset value", 32'h0, q[15:0]);
    @(posedge clk) req_in <= 1'b1;
    @(posedge clk) req_in <= 1'b0;
    flag = 1'b1;
    repeat (3) @(posedge clk);
    chk("irq masked", 32'h0, irq);
    for (int i = 0; i < 8; i++)
      step(12'hEA0, (16'h0100 << i) | 16'h00FF, 4'hF);
    step(12'hFA0, 16'h0000, 4'h3);
    for (int i = 0; i < 8; i++)
      step(12'hFA0, 16'h0100 << i, 4'h3);
    step(12'hEA0, 16'h1010, 4'h1);
    step(12'hEA0, 16'h1010, 4'hC);
    step(12'hE10, 16'hFFFF, 4'hF);
    step(12'h0A0, 16'hFFFF, 4'hF);
    step(12'hEA0, 16'h3030, 4'hF);
    step(12'hFA0, 16'h1010, 4'hF);
    step(12'hEA0, 16'h1000, 4'hF);
    step(12'hEA0, 16'h1010, 4'hF);
    axi_rd(12'hE20);
    chk("unmapped rresp", ccc_pkg::RESP_SLVERR, r);
    chk("unmapped rdata", 32'h0, q);
    sr_chk(sr(1'b0, 1'b0, 1'b1));
    @(posedge clk) done_in <= 1'b1;
    @(posedge clk) done_in <= 1'b0;
    step(12'hFA0, 16'h8080, 4'hF);
    @(posedge clk) open_in <= 1'b1;
    sr_chk(sr(1'b1, 1'b1, 1'b1));
    axi_wr(12'hEA2, 32'h0000_0010, 4'hF);
    chk("status bresp", ccc_pkg::RESP_OKAY, r);
    sr_chk(sr(1'b1, 1'b0, 1'b1));
    step(12'hEA0, 16'h8000, 4'hF);
    sr_chk(sr(1'b0, 1'b0, 1'b1));
    @(posedge clk) done_in <= 1'b1;
    axi_wr(12'hEA2, 32'h0000_0011, 4'hF);
    done_in <= 1'b0;
    flag = 1'b0;
    sr_chk(sr(1'b0, 1'b1, 1'b0));
    @(posedge clk) ce <= 1'b0;
    req_in <= 1'b1;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    req_in <= 1'b0;
    sr_chk(sr(1'b0, 1'b1, 1'b0));
    @(posedge clk) req_in <= 1'b1;
    @(posedge clk) req_in <= 1'b0;
    flag = 1'b1;
    repeat (60)
      step({($random(seed) & 1) != 0 ? 4'hE : 4'hF, 8'hA0},
           16'($random(seed)), 4'($random(seed)));
    print_verdict;
  end
endmodule
